// >>> bench/wdr_watchdog_chk.sv
// Assertion checker for the watchdog block ports
`timescale 1ns/10ps
module wdr_watchdog_chk import wdr_pkg::*; #(
	parameter int PULSE_CYCLES = RST_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrRdData,
	input wire logic wdtReset,
	input wire logic wdtActive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [19:0] hiCnt_ff;
	// Length of the current reset pulse
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			hiCnt_ff <= 20'h00000;
		else
			hiCnt_ff <= wdtReset ? hiCnt_ff + 20'h00001 : 20'h00000;
	end
	sequence keyWr;
		sfrWrEn && sfrAddr == KEY_ADDR && !wdtReset;
	endsequence
	sequence keyRd;
		sfrRdEn && !sfrWrEn && sfrAddr == KEY_ADDR && !wdtReset;
	endsequence
	sequence svcWr;
		sfrWrEn && sfrAddr == SERVICE_ADDR && !wdtReset && sfrWrData[6:0] != 7'h7f;
	endsequence
	chk_pulse_len: assert property ($fell(wdtReset) |-> hiCnt_ff == PULSE_CYCLES)
		else $error("reset pulse length wrong");
	chk_pulse_max: assert property (hiCnt_ff <= PULSE_CYCLES)
		else $error("reset pulse too long");
	chk_active_off: assert property (wdtReset |-> !wdtActive)
		else $error("active during reset pulse");
	chk_rst_enabled: assert property ($rose(wdtReset) |-> $past(wdtActive))
		else $error("overflow while disabled");
	chk_key_off: assert property (keyWr ##0 sfrWrData == KEY_DISABLE |=> !wdtActive)
		else $error("disable key ignored");
	chk_key_on: assert property (keyWr ##0 sfrWrData != KEY_DISABLE |=> wdtActive || wdtReset)
		else $error("other key stopped counting");
	chk_svc_quiet: assert property (svcWr |=> !wdtReset [*8])
		else $error("reset soon after service write");
	chk_rd_unmap: assert property (sfrRdEn && sfrAddr != KEY_ADDR && sfrAddr != SERVICE_ADDR
		|=> sfrRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_rd_hold: assert property (!sfrRdEn |=> $stable(sfrRdData))
		else $error("read data moved without strobe");
	chk_key_back: assert property (keyWr ##1 keyRd |=> sfrRdData == $past(sfrWrData, 2))
		else $error("key read back wrong");
	chk_pulse_end: assert property ($fell(wdtReset) |-> wdtActive)
		else $error("not active after pulse");
endmodule : wdr_watchdog_chk

bind wdr_watchdog wdr_watchdog_chk #(.PULSE_CYCLES(PULSE_CYCLES)) wdr_watchdog_chk_inst (
	.clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn),
	.sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .wdtReset(wdtReset), .wdtActive(wdtActive));

// >>> bench/wdr_watchdog_tb_top.sv
// Self-checking bench for the watchdog block
`timescale 1ns/10ps
module wdr_watchdog_tb_top import wdr_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrWrEn = 1'b0;
	logic sfrRdEn = 1'b0;
	logic [7:0] sfrRdData;
	logic wdtReset;
	logic wdtActive;
	logic [7:0] keys [6] = '{8'h00, 8'h55, 8'h54, 8'h55, 8'haa, 8'hd5};
	int failures = 0;
	int samples_checked = 0;
	int n;
	// Scaled machine cycle keeps the run short; a 7e preset leaves 2^16 ticks
	localparam int TB_MC_DIV = 1;
	localparam int OVF_TICKS = 65536;
	localparam int OVF_MIN = (OVF_TICKS - 1) * TB_MC_DIV + 1;
	localparam int OVF_MAX = OVF_TICKS * TB_MC_DIV;
	always #2 clk = ~clk;
	wdr_watchdog #(.PULSE_CYCLES(8), .MC_DIV(TB_MC_DIV)) wdr_watchdog_inst (
		.clk(clk), .sys_rst(sys_rst),
		.sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData), .wdtReset(wdtReset), .wdtActive(wdtActive));
	task print_verdict();
		$display("comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Never call two writes back to back: the strobe would be assigned twice
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrEn <= 1'b1;
		@(posedge clk);
		sfrWrEn <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge clk);
		sfrRdEn <= 1'b0;
		@(negedge clk);
		chk(sfrRdData, exp);
		@(posedge clk);
	endtask : rd
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk(sfrRdData, 8'h00);
		chk({7'h00, wdtActive}, 8'h01);
		@(posedge clk);
		rd(KEY_ADDR, KEY_RESET);
		rd(SERVICE_ADDR, 8'h00);
		rd(8'h80, 8'h00);
		$display("test reset done");
		wr(SERVICE_ADDR, 8'h7e);
		rd(SERVICE_ADDR, 8'h7e);
		wr(SERVICE_ADDR, 8'hfe);
		rd(SERVICE_ADDR, 8'h7e);
		wr(SERVICE_ADDR, 8'h00);
		rd(SERVICE_ADDR, 8'h00);
		$display("test service done");
		foreach (keys[i]) begin
			wr(KEY_ADDR, keys[i]);
			rd(KEY_ADDR, keys[i]);
			chk({7'h00, wdtActive}, {7'h00, keys[i] != KEY_DISABLE});
		end
		$display("test key done");
		repeat (4) begin
			repeat (64) @(posedge clk);
			wr(SERVICE_ADDR, 8'h00);
			rd(SERVICE_ADDR, 8'h00);
		end
		chk({7'h00, wdtReset}, 8'h00);
		$display("test periodic service done");
		wr(SERVICE_ADDR, 8'h7e);
		n = 0;
		@(negedge clk);
		while (wdtReset !== 1'b1 && n < OVF_MAX + 64) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, n >= OVF_MIN && n <= OVF_MAX}, 8'h01);
		chk({7'h00, wdtActive}, 8'h00);
		n = 0;
		while (wdtReset === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(n[7:0], 8'h08);
		@(posedge clk);
		rd(KEY_ADDR, KEY_RESET);
		rd(SERVICE_ADDR, 8'h00);
		chk({7'h00, wdtActive}, 8'h01);
		$display("test overflow done");
		print_verdict();
	end
	initial begin
		repeat (70000) @(posedge clk);
		failures++;
		print_verdict();
	end
endmodule : wdr_watchdog_tb_top

// >>> rtl/wdr_mc_tick.sv
// Machine-cycle tick generator: one pulse every DIV clocks
`timescale 1ns/10ps
module wdr_mc_tick import wdr_pkg::*; #(
	parameter int DIV = MC_CLKS
) (
	input wire logic clk,
	input wire logic sys_rst,
	output logic tick
);

	typedef struct packed {
		logic [MC_CNT_W-1:0] phase;
		logic tick;
	} wdr_tick_st_t;

	localparam logic [MC_CNT_W-1:0] LAST_PHASE = MC_CNT_W'(DIV - 1);

	wdr_tick_st_t st_ff;
	wdr_tick_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.phase == LAST_PHASE) begin
			nxt_st.phase = MC_CNT_RESET;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.phase = st_ff.phase + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '{phase: MC_CNT_RESET, tick: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;

endmodule : wdr_mc_tick

// >>> rtl/wdr_pkg.sv
// Shared constants and types of the watchdog overflow reset block
package wdr_pkg;

	// Special-function addresses seen on the core's internal register port
	localparam logic [7:0] KEY_ADDR = 8'hae;
	localparam logic [7:0] SERVICE_ADDR = 8'ha6;

	// Guard key encodings
	localparam logic [7:0] KEY_DISABLE = 8'h55;
	localparam logic [7:0] KEY_RESET = 8'h00;

	// Counter layout: preset field on top, cleared field below
	localparam int CNT_W = 22;
	localparam int PRESET_W = 7;
	localparam int LOW_W = 15;
	localparam int PRESET_LSB = 15;
	localparam logic [CNT_W-1:0] CNT_RESET = 22'h000000;
	localparam logic [CNT_W-1:0] CNT_MAX = 22'h3fffff;
	localparam logic [LOW_W-1:0] LOW_CLEAR = 15'h0000;

	// Timing: the core clock is the oscillator, 4 ns per period
	localparam int CLK_PERIOD_NS = 4;
	localparam int OSC_PERIOD_NS = 4;
	localparam int MC_OSC_PERIODS = 12;
	localparam int MC_CLKS = (MC_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_PULSE_MC = 32768;
	localparam int RST_PULSE_CYCLES = MC_CLKS * RST_PULSE_MC;

	// Machine-cycle prescaler and reset pulse counter widths
	localparam int MC_CNT_W = 4;
	localparam logic [MC_CNT_W-1:0] MC_CNT_RESET = 4'h0;
	localparam int PULSE_CNT_W = 19;
	localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RESET = 19'h00000;

	// Register read data reset value
	localparam logic [7:0] RDATA_RESET = 8'h00;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_PULSE = 2'b10
	} wdr_state_t;

	typedef struct packed {
		wdr_state_t state;
		logic [CNT_W-1:0] count;
		logic [7:0] key;
		logic [7:0] rdData;
		logic rstOut;
		logic active;
	} wdr_core_t;

	localparam wdr_core_t CORE_RESET = '{
		state: ST_RUN,
		count: CNT_RESET,
		key: KEY_RESET,
		rdData: RDATA_RESET,
		rstOut: 1'b0,
		active: 1'b1
	};

endpackage : wdr_pkg

// >>> rtl/wdr_pulse_timer.sv
// Fixed-length pulse timer: runs CYCLES clocks after a start strobe
`timescale 1ns/10ps
module wdr_pulse_timer import wdr_pkg::*; #(
	parameter int CYCLES = RST_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	output logic lastCycle
);

	typedef struct packed {
		logic [PULSE_CNT_W-1:0] remain;
		logic busy;
	} wdr_pulse_st_t;

	localparam logic [PULSE_CNT_W-1:0] LOAD_VAL = PULSE_CNT_W'(CYCLES - 1);

	wdr_pulse_st_t st_ff;
	wdr_pulse_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (start && !st_ff.busy) begin
			nxt_st.busy = 1'b1;
			nxt_st.remain = LOAD_VAL;
		end else if (st_ff.busy) begin
			if (st_ff.remain == PULSE_CNT_RESET) begin
				nxt_st.busy = 1'b0;
			end else begin
				nxt_st.remain = st_ff.remain - 19'h00001;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '{remain: PULSE_CNT_RESET, busy: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// High in the final clock of the pulse
	assign lastCycle = st_ff.busy && (st_ff.remain == PULSE_CNT_RESET);

endmodule : wdr_pulse_timer

// >>> rtl/wdr_watchdog.sv
// Watchdog overflow reset: 22-bit machine-cycle counter, service and key registers
//
// Contract
// - Overflow of the watchdog counter asserts a system reset of the whole controller.
// - Counter and reset generation keep running in Idle; Idle never freezes them.
// - The timing element is a 22-bit counter with a writable service and key register.
// - The watchdog runs from reset onward with no software action to start it.
// - The counter advances by exactly one per machine cycle.
// - Overflow is seen after 4194304 machine cycles from zero, at the wrap past the maximum.
// - A service write loads the value into the top seven bits of the counter.
// - Writing zero to the service register leaves the whole counter at zero.
// - The watchdog is disabled only while the key register holds 55 hex.
// - Every other key value keeps the watchdog enabled and counting.
// - Full timeout from zero is twelve oscillator periods times two to the 22nd.
// - The generated reset pulse lasts twelve oscillator periods times two to the 15th.
// - The key register is one 8-bit register at address 0AEh, all bits forming the key.
`timescale 1ns/10ps
module wdr_watchdog import wdr_pkg::*; #(
	parameter int PULSE_CYCLES = RST_PULSE_CYCLES,
	// Clocks per machine cycle; lowered only to shorten simulation runs
	parameter int MC_DIV = MC_CLKS
) (
	// Core clock, equal to the oscillator
	input wire logic clk,
	// Power-on and external reset
	input wire logic sys_rst,
	// Special-function register port of the core
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	// System reset request to the rest of the controller
	output logic wdtReset,
	// Counting status
	output logic wdtActive
);

	wdr_core_t st_ff;
	wdr_core_t nxt_st;

	logic mcTick;
	logic pulseLast;
	logic keyWrite;
	logic serviceWrite;
	logic keyRead;
	logic serviceRead;
	logic counting;
	logic overflow;
	logic startPulse;

	// Machine cycle is twelve core clocks
	wdr_mc_tick #(
		.DIV(MC_DIV)
	) u_mc_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(mcTick)
	);

	// Reset pulse length counter
	wdr_pulse_timer #(
		.CYCLES(PULSE_CYCLES)
	) u_pulse_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(startPulse),
		.lastCycle(pulseLast)
	);

	// Register decode
	always_comb begin
		keyWrite = sfrWrEn && (sfrAddr == KEY_ADDR);
		serviceWrite = sfrWrEn && (sfrAddr == SERVICE_ADDR);
		keyRead = sfrRdEn && (sfrAddr == KEY_ADDR);
		serviceRead = sfrRdEn && (sfrAddr == SERVICE_ADDR);
	end

	// Enable decision: only the exact disable key stops counting
	always_comb begin
		counting = (st_ff.state == ST_RUN) && (st_ff.key != KEY_DISABLE);
	end

	// Wrap past the 22-bit maximum on a counting machine cycle
	always_comb begin
		overflow = counting && mcTick && (st_ff.count == CNT_MAX) && !serviceWrite;
		startPulse = overflow;
	end

	// Next-state logic of the core
	always_comb begin
		nxt_st = st_ff;
		case (st_ff.state)
			ST_RUN: begin
				if (overflow) begin
					// Counter wraps to zero and the reset pulse begins
					nxt_st.state = ST_PULSE;
					nxt_st.count = CNT_RESET;
				end else if (serviceWrite) begin
					// Service beats a same-cycle increment
					nxt_st.count = {sfrWrData[PRESET_W-1:0], LOW_CLEAR};
				end else if (counting && mcTick) begin
					nxt_st.count = st_ff.count + 22'h000001;
				end
				if (keyWrite) begin
					nxt_st.key = sfrWrData;
				end
			end
			ST_PULSE: begin
				// The whole controller is held in reset; register writes are ignored
				nxt_st.count = CNT_RESET;
				nxt_st.key = KEY_RESET;
				if (pulseLast) begin
					nxt_st.state = ST_RUN;
				end
			end
			default: begin
				nxt_st.state = ST_RUN;
				nxt_st.count = CNT_RESET;
				nxt_st.key = KEY_RESET;
			end
		endcase

		// Read data holds until the next read strobe
		if (keyRead) begin
			nxt_st.rdData = st_ff.key;
		end else if (serviceRead) begin
			nxt_st.rdData = {1'b0, st_ff.count[CNT_W-1:PRESET_LSB]};
		end else if (sfrRdEn) begin
			nxt_st.rdData = RDATA_RESET;
		end

		nxt_st.rstOut = (nxt_st.state == ST_PULSE);
		nxt_st.active = (nxt_st.state == ST_RUN) && (nxt_st.key != KEY_DISABLE);
	end

	// Counter starts at zero and enabled straight out of reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= CORE_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sfrRdData = st_ff.rdData;
	assign wdtReset = st_ff.rstOut;
	assign wdtActive = st_ff.active;

endmodule : wdr_watchdog
